// >>> pkg/sfc_defines.svh
// Constants of the serial flash command front end
`ifndef SFC_DEFINES_SVH
`define SFC_DEFINES_SVH
`define SFC_CLK_NS 10
`define SFC_T_CS_NS 250
`define SFC_CS_CYC ((`SFC_T_CS_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS)
`define SFC_T_PWR_MS 20
`define SFC_PWR_CYC (`SFC_T_PWR_MS * 1000000 / `SFC_CLK_NS)
`define SFC_SCK_HALF 4'h7
`define SFC_P_CS 0
`define SFC_P_SCK 1
`define SFC_P_SI 2
`define SFC_P_WP 3
`define SFC_P_RST 4
`define SFC_PAGE_HI 19
`define SFC_PAGE_LO 9
`define SFC_BYTE_HI 8
`define SFC_BLK_LO 3
`define SFC_PROT_PAGES 11'h100
`define SFC_DUM_ARRAY 3'h4
`define SFC_DUM_BUF 3'h1
`define SFC_ADDR_LAST 3'h2
`define SFC_BIT_LAST 3'h7
`define SFC_CPOL_RST 1'h1
`define SFC_OP_ARD_L 8'h68
`define SFC_OP_ARD 8'hE8
`define SFC_OP_PRD_L 8'h52
`define SFC_OP_PRD 8'hD2
`define SFC_OP_B1RD_L 8'h54
`define SFC_OP_B1RD 8'hD4
`define SFC_OP_B2RD_L 8'h56
`define SFC_OP_B2RD 8'hD6
`define SFC_OP_STAT_L 8'h57
`define SFC_OP_STAT 8'hD7
`define SFC_OP_B1WR 8'h84
`define SFC_OP_B2WR 8'h87
`define SFC_OP_B1PGE 8'h83
`define SFC_OP_B2PGE 8'h86
`define SFC_OP_B1PG 8'h88
`define SFC_OP_B2PG 8'h89
`define SFC_OP_PERASE 8'h81
`define SFC_OP_BERASE 8'h50
`define SFC_OP_PTB1 8'h82
`define SFC_OP_PTB2 8'h85
`define SFC_OP_XF1 8'h53
`define SFC_OP_XF2 8'h55
`define SFC_OP_CMP1 8'h60
`define SFC_OP_CMP2 8'h61
`define SFC_OP_RW1 8'h58
`define SFC_OP_RW2 8'h59
`endif

// >>> pkg/sfc_pkg.sv
// Types and opcode decoding shared by both ends
package sfc_pkg;
`include "sfc_defines.svh"

  typedef enum logic [2:0] {SFC_C_BAD, SFC_C_STATUS, SFC_C_RD_ARRAY, SFC_C_RD_BUF,
                            SFC_C_WR_BUF, SFC_C_PROG_BUF, SFC_C_ARRAY} sfc_class_t;

  typedef enum logic [2:0] {SFC_D_IDLE, SFC_D_OPC, SFC_D_ADDR, SFC_D_DUMMY,
                            SFC_D_DIN, SFC_D_DOUT, SFC_D_IGNORE} sfc_dstate_t;

  typedef enum logic [2:0] {SFC_H_PWR, SFC_H_IDLE, SFC_H_SETUP, SFC_H_LEAD,
                            SFC_H_RUN, SFC_H_HOLD, SFC_H_GAP} sfc_hstate_t;

  function automatic sfc_class_t sfc_classify(input logic [7:0] op);
    case (op)
      `SFC_OP_STAT_L, `SFC_OP_STAT: return SFC_C_STATUS;
      `SFC_OP_ARD_L, `SFC_OP_ARD, `SFC_OP_PRD_L, `SFC_OP_PRD: return SFC_C_RD_ARRAY;
      `SFC_OP_B1RD_L, `SFC_OP_B1RD, `SFC_OP_B2RD_L, `SFC_OP_B2RD: return SFC_C_RD_BUF;
      `SFC_OP_B1WR, `SFC_OP_B2WR: return SFC_C_WR_BUF;
      `SFC_OP_PTB1, `SFC_OP_PTB2: return SFC_C_PROG_BUF;
      `SFC_OP_B1PGE, `SFC_OP_B2PGE, `SFC_OP_B1PG, `SFC_OP_B2PG, `SFC_OP_PERASE, `SFC_OP_BERASE,
      `SFC_OP_XF1, `SFC_OP_XF2, `SFC_OP_CMP1, `SFC_OP_CMP2, `SFC_OP_RW1, `SFC_OP_RW2: return SFC_C_ARRAY;
      default: return SFC_C_BAD;
    endcase
  endfunction

  function automatic logic [2:0] sfc_dummy(input sfc_class_t c);
    return (c == SFC_C_RD_ARRAY) ? `SFC_DUM_ARRAY : (c == SFC_C_RD_BUF) ? `SFC_DUM_BUF : 3'h0;
  endfunction

  function automatic logic sfc_buf2(input logic [7:0] op);
    return op inside {`SFC_OP_B2RD_L, `SFC_OP_B2RD, `SFC_OP_B2WR, `SFC_OP_B2PGE, `SFC_OP_B2PG,
                      `SFC_OP_PTB2, `SFC_OP_XF2, `SFC_OP_CMP2, `SFC_OP_RW2};
  endfunction

  function automatic logic sfc_reprograms(input logic [7:0] op);
    return op inside {`SFC_OP_B1PGE, `SFC_OP_B2PGE, `SFC_OP_B1PG, `SFC_OP_B2PG, `SFC_OP_PERASE,
                      `SFC_OP_BERASE, `SFC_OP_PTB1, `SFC_OP_PTB2, `SFC_OP_RW1, `SFC_OP_RW2};
  endfunction

  typedef struct packed {
    logic [4:0]  sync1;
    logic [4:0]  sync2;
    logic [4:0]  prev;
    sfc_dstate_t state;
    logic        cpol;
    logic [7:0]  sh;
    logic [2:0]  bitc;
    logic [2:0]  bytec;
    logic [7:0]  op;
    sfc_class_t  cls;
    logic [15:0] addr;
    logic        exec_armed;
    logic        so;
    logic        so_oe;
    logic [7:0]  osh;
    logic [2:0]  ocnt;
    logic        rdy_oe;
    logic        cmd_valid;
    logic [10:0] cmd_page;
    logic [8:0]  cmd_byte;
    logic        cmd_exec;
    logic        cmd_refused;
    logic        rd_req;
    logic [1:0][7:0] fifo;
    logic        wptr;
    logic        rptr;
    logic [1:0]  fcnt;
    logic        wr_valid;
    logic [7:0]  wr_data;
    logic        overrun;
  } sfc_dev_t;

  typedef struct packed {
    sfc_hstate_t state;
    logic [20:0] cnt;
    logic [3:0]  div;
    logic        cpol;
    logic        cs_n;
    logic        sck;
    logic        si;
    logic [7:0]  sh;
    logic [7:0]  rsh;
    logic [2:0]  bitc;
    logic        rise_seen;
    logic [9:0]  bidx;
    logic [9:0]  dend;
    logic [9:0]  total;
    logic [7:0]  op;
    sfc_class_t  cls;
    logic [23:0] addr;
    logic [1:0]  sync1;
    logic [1:0]  sync2;
    logic        wp_n;
    logic        rst_n;
    logic        ready;
    logic        tx_ack;
    logic        rx_valid;
    logic [7:0]  rx_data;
    logic        refused;
  } sfc_host_t;
endpackage

// >>> pkg/sfc_if.sv
// Serial link between host master and flash front end
`timescale 1ns/1ps
interface sfc_if;
  logic cs_n;
  logic sck;
  logic si;
  logic wp_n;
  logic rst_n;
  logic so;
  logic so_oe;
  logic rdy_oe;
  wire  so_line;
  wire  rdy_line;

  // Undriven output shows the inverse of its last bit, so a stale sample cannot pass; ready line has a pull-up
  assign so_line  = so_oe ? so : ~so;
  assign rdy_line = rdy_oe ? 1'b0 : 1'b1;

  modport dev (input cs_n, sck, si, wp_n, rst_n, output so, so_oe, rdy_oe);
  modport host (output cs_n, sck, si, wp_n, rst_n, input so_line, rdy_line);
endinterface

// >>> hdl/sfc_host.sv
// Host serial master: frames one command per start request
`timescale 1ns/1ps
module sfc_host
  import sfc_pkg::*;
#(
  parameter int POWER_CYC = `SFC_PWR_CYC
)(
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  // Link
  sfc_if.host              bus,
  // Command request
  input  wire logic        i_start,
  input  wire logic [7:0]  i_op,
  input  wire logic [10:0] i_page,
  input  wire logic [8:0]  i_byte,
  input  wire logic [8:0]  i_len,
  input  wire logic        i_cpol,
  input  wire logic        i_wp_n,
  input  wire logic        i_chip_rst_n,
  output logic             o_ready,
  output logic             o_refused,
  output logic             o_busy,
  // Write data
  input  wire logic        i_tx_valid,
  input  wire logic [7:0]  i_tx_data,
  output logic             o_tx_ack,
  // Read data
  output logic             o_rx_valid,
  output logic [7:0]       o_rx_data
);
  `include "sfc_defines.svh"

  sfc_host_t r;
  sfc_host_t n;
  logic      tick;
  logic      wr_data_byte;
  logic      rd_data_byte;
  logic [7:0] nb;
  sfc_class_t sc;

  always_comb
  begin
    n = r;
    nb = 8'h00;
    sc = sfc_classify(i_op);
    n.sync1 = {bus.rdy_line, bus.so_line};
    n.sync2 = r.sync1;
    n.wp_n = i_wp_n;
    n.rst_n = i_chip_rst_n;
    n.tx_ack = 1'b0;
    n.rx_valid = 1'b0;
    n.refused = 1'b0;
    n.cnt = r.cnt + 21'h1;
    tick = (r.div == `SFC_SCK_HALF);
    n.div = tick ? 4'h0 : r.div + 4'h1;
    wr_data_byte = (r.bidx >= r.dend) && (r.cls inside {SFC_C_WR_BUF, SFC_C_PROG_BUF});
    rd_data_byte = (r.bidx >= r.dend) && (r.cls inside {SFC_C_STATUS, SFC_C_RD_ARRAY, SFC_C_RD_BUF});
    unique case (r.bidx)
      10'h0: nb = r.op;
      10'h1: nb = r.addr[23:16];
      10'h2: nb = r.addr[15:8];
      10'h3: nb = r.addr[7:0];
      default: nb = wr_data_byte ? i_tx_data : 8'h00;
    endcase
    if (r.bidx < r.dend && r.bidx >= 10'h1 && r.cls == SFC_C_STATUS)
    begin
      nb = 8'h00;
    end
    unique case (r.state)
      SFC_H_PWR:
      begin
        if (r.cnt == 21'(POWER_CYC - 1))
        begin
          n.state = SFC_H_IDLE;
          n.ready = 1'b1;
        end
      end
      SFC_H_IDLE:
      begin
        n.sck = r.cpol;
        if (i_start)
        begin
          n.ready = 1'b0;
          if (r.sync2[1] == 1'b0 && !(sc inside {SFC_C_STATUS, SFC_C_RD_BUF, SFC_C_WR_BUF}))
          begin
            n.refused = 1'b1;
            n.ready = 1'b1;
          end
          else
          begin
            n.op = i_op;
            n.cls = sc;
            n.addr = {4'h0, i_page, i_byte};
            n.dend = (sc == SFC_C_STATUS) ? 10'h1 : 10'h4 + 10'(sfc_dummy(sc));
            n.total = ((sc == SFC_C_STATUS) ? 10'h1 : 10'h4 + 10'(sfc_dummy(sc)))
                      + ((sc == SFC_C_ARRAY) ? 10'h0 : 10'(i_len));
            n.cpol = i_cpol;
            n.sck = i_cpol;
            n.bidx = 10'h0;
            n.cnt = 21'h0;
            n.state = SFC_H_SETUP;
          end
        end
      end
      SFC_H_SETUP:
      begin
        if (r.cnt == 21'(`SFC_CS_CYC - 1))
        begin
          n.cs_n = 1'b0;
          n.sh = {nb[6:0], 1'b0};
          n.si = nb[7];
          n.bitc = 3'h0;
          n.rise_seen = 1'b0;
          n.cnt = 21'h0;
          n.state = SFC_H_LEAD;
        end
      end
      SFC_H_LEAD:
      begin
        if (r.cnt == 21'(`SFC_CS_CYC - 1))
        begin
          n.div = 4'h0;
          n.state = SFC_H_RUN;
        end
      end
      SFC_H_RUN:
      begin
        if (tick && !r.sck)
        begin
          n.sck = 1'b1;
          n.rise_seen = 1'b1;
          n.rsh = {r.rsh[6:0], r.sync2[0]};
          n.bitc = r.bitc + 3'h1;
          if (r.bitc == `SFC_BIT_LAST)
          begin
            n.rx_valid = rd_data_byte;
            n.rx_data = {r.rsh[6:0], r.sync2[0]};
            n.bidx = r.bidx + 10'h1;
            if (r.bidx == r.total - 10'h1)
            begin
              n.cnt = 21'h0;
              n.state = SFC_H_HOLD;
            end
          end
        end
        else if (tick)
        begin
          if (r.rise_seen && r.bitc == 3'h0)
          begin
            if (wr_data_byte && !i_tx_valid)
            begin
              n.div = r.div;
            end
            else
            begin
              n.tx_ack = wr_data_byte;
              n.sh = {nb[6:0], 1'b0};
              n.si = nb[7];
              n.sck = 1'b0;
            end
          end
          else
          begin
            n.si = r.rise_seen ? r.sh[7] : r.si;
            n.sh = r.rise_seen ? {r.sh[6:0], 1'b0} : r.sh;
            n.sck = 1'b0;
          end
        end
      end
      SFC_H_HOLD:
      begin
        n.sck = r.cpol;
        if (r.cnt == 21'(`SFC_CS_CYC - 1))
        begin
          n.cs_n = 1'b1;
          n.cnt = 21'h0;
          n.state = SFC_H_GAP;
        end
      end
      SFC_H_GAP:
      begin
        if (r.cnt == 21'(`SFC_CS_CYC - 1))
        begin
          n.ready = 1'b1;
          n.state = SFC_H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      r <= '0;
      r.cs_n <= 1'b1;
      r.sck <= `SFC_CPOL_RST;
      r.cpol <= `SFC_CPOL_RST;
      r.sync1 <= 2'h3;
      r.sync2 <= 2'h3;
    end
    else
    begin
      r <= n;
    end
  end

  assign bus.cs_n = r.cs_n;
  assign bus.sck = r.sck;
  assign bus.si = r.si;
  assign bus.wp_n = r.wp_n;
  assign bus.rst_n = r.rst_n;
  assign o_ready = r.ready;
  assign o_refused = r.refused;
  assign o_busy = ~r.sync2[1];
  assign o_tx_ack = r.tx_ack;
  assign o_rx_valid = r.rx_valid;
  assign o_rx_data = r.rx_data;
endmodule // sfc_host

// >>> hdl/sfc_device.sv
// Flash front end: select framing, command decode, data shifting
// Notes on behaviour
// - All input bits come from serial data input
// - Sample on rising clock, shift out falling
// - Deselected: ignore input, output stays floating
// - Operations framed by select falling and rising
// - Write protect low blocks reprogramming pages below 256
// - Reset pin low aborts, returns to idle
// - Held in reset while pin stays low
// - Power-on reset needs no pin sequencing
// - Ready/busy pulled low during self-timed work
// - Busy blocks array and active buffer only
// - After reset: mode 3, floating, await select
// - Select falling samples clock idle level
// - Host waits 20 ms after power-up
// - Opcode, reserved, page, byte address, MSB first
// - Buffer commands use only low nine bits
// - Host avoids overlapping array operations
`timescale 1ns/1ps
module sfc_device
  import sfc_pkg::*;
(
  // Clock and power-on reset
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  // Link
  sfc_if.dev               bus,
  // Decoded command
  output logic             o_cmd_valid,
  output logic [7:0]       o_cmd_op,
  output logic [10:0]      o_cmd_page,
  output logic [8:0]       o_cmd_byte,
  output logic             o_cmd_exec,
  output logic             o_cmd_refused,
  output logic             o_cpol,
  // Engine status
  input  wire logic        i_busy,
  input  wire logic        i_busy_buf2,
  // Read data
  output logic             o_rd_req,
  input  wire logic [7:0]  i_rd_data,
  // Write data stream
  output logic             o_wr_valid,
  output logic [7:0]       o_wr_data,
  input  wire logic        i_wr_ready,
  output logic             o_wr_overrun
);
  `include "sfc_defines.svh"

  sfc_dev_t   r;
  sfc_dev_t   n;
  logic       cs_fall;
  logic       sck_rise;
  logic       sck_fall;
  logic [7:0] sh_new;
  logic [23:0] full;
  logic [10:0] page;
  logic [8:0] byte_a;
  logic       refuse;
  logic       pop;

  always_comb
  begin
    n = r;
    full = {r.addr, 8'h00};
    page = 11'h000;
    byte_a = 9'h000;
    refuse = 1'b0;
    n.sync1 = {bus.rst_n, bus.wp_n, bus.si, bus.sck, bus.cs_n};
    n.sync2 = r.sync1;
    n.prev = r.sync2;
    cs_fall = r.prev[`SFC_P_CS] && !r.sync2[`SFC_P_CS];
    sck_rise = !r.prev[`SFC_P_SCK] && r.sync2[`SFC_P_SCK];
    sck_fall = r.prev[`SFC_P_SCK] && !r.sync2[`SFC_P_SCK];
    sh_new = {r.sh[6:0], r.sync2[`SFC_P_SI]};
    n.cmd_valid = 1'b0;
    n.cmd_exec = 1'b0;
    n.cmd_refused = 1'b0;
    n.rd_req = 1'b0;
    n.rdy_oe = i_busy;
    pop = r.wr_valid && i_wr_ready;
    if (pop)
    begin
      n.rptr = ~r.rptr;
      n.fcnt = r.fcnt - 2'h1;
    end
    if (!r.sync2[`SFC_P_RST])
    begin
      n.state = SFC_D_IDLE;
      n.cpol = `SFC_CPOL_RST;
      n.so_oe = 1'b0;
      n.exec_armed = 1'b0;
    end
    else if (r.sync2[`SFC_P_CS])
    begin
      n.cmd_exec = r.exec_armed && r.state != SFC_D_IDLE;
      n.state = SFC_D_IDLE;
      n.so_oe = 1'b0;
      n.exec_armed = 1'b0;
    end
    else if (cs_fall)
    begin
      n.cpol = r.sync2[`SFC_P_SCK];
      n.state = SFC_D_OPC;
      n.bitc = 3'h0;
      n.ocnt = 3'h0;
    end
    else
    begin
      if (sck_rise && r.state != SFC_D_IDLE && r.state != SFC_D_IGNORE)
      begin
        n.sh = sh_new;
        n.bitc = r.bitc + 3'h1;
        if (r.bitc == `SFC_BIT_LAST)
        begin
          unique case (r.state)
            SFC_D_OPC:
            begin
              n.op = sh_new;
              n.cls = sfc_classify(sh_new);
              n.bytec = 3'h0;
              n.cmd_page = 11'h000;
              n.cmd_byte = 9'h000;
              if (sfc_classify(sh_new) == SFC_C_BAD)
              begin
                n.state = SFC_D_IGNORE;
              end
              else if (sfc_classify(sh_new) == SFC_C_STATUS)
              begin
                n.cmd_valid = 1'b1;
                n.rd_req = 1'b1;
                n.so_oe = 1'b1;
                n.state = SFC_D_DOUT;
              end
              else
              begin
                n.state = SFC_D_ADDR;
              end
            end
            SFC_D_ADDR:
            begin
              if (r.bytec != `SFC_ADDR_LAST)
              begin
                n.addr = {r.addr[7:0], sh_new};
                n.bytec = r.bytec + 3'h1;
              end
              else
              begin
                full = {r.addr, sh_new};
                page = full[`SFC_PAGE_HI:`SFC_PAGE_LO];
                byte_a = full[`SFC_BYTE_HI:0];
                // buffer ops keep only byte bits
                if (r.cls inside {SFC_C_RD_BUF, SFC_C_WR_BUF})
                begin
                  page = 11'h000;
                end
                if (r.cls == SFC_C_ARRAY)
                begin
                  byte_a = 9'h000;
                end
                // block select from upper page bits
                if (r.op == `SFC_OP_BERASE)
                begin
                  page = {page[10:`SFC_BLK_LO], 3'h0};
                end
                // busy blocks array and busy buffer
                refuse = i_busy && (r.cls inside {SFC_C_RD_ARRAY, SFC_C_PROG_BUF, SFC_C_ARRAY});
                refuse = refuse || (i_busy && (r.cls inside {SFC_C_RD_BUF, SFC_C_WR_BUF})
                                    && sfc_buf2(r.op) == i_busy_buf2);
                refuse = refuse || (!r.sync2[`SFC_P_WP] && sfc_reprograms(r.op)
                                    && page < `SFC_PROT_PAGES);
                n.cmd_page = page;
                n.cmd_byte = byte_a;
                n.bytec = 3'h0;
                if (refuse)
                begin
                  n.cmd_refused = 1'b1;
                  n.state = SFC_D_IGNORE;
                end
                else
                begin
                  n.cmd_valid = 1'b1;
                  n.exec_armed = r.cls inside {SFC_C_PROG_BUF, SFC_C_ARRAY};
                  if (sfc_dummy(r.cls) != 3'h0)
                  begin
                    n.state = SFC_D_DUMMY;
                  end
                  else if (r.cls inside {SFC_C_WR_BUF, SFC_C_PROG_BUF})
                  begin
                    n.state = SFC_D_DIN;
                  end
                  else
                  begin
                    n.state = SFC_D_IGNORE;
                  end
                end
              end
            end
            SFC_D_DUMMY:
            begin
              n.bytec = r.bytec + 3'h1;
              if (r.bytec == sfc_dummy(r.cls) - 3'h1)
              begin
                n.rd_req = 1'b1;
                n.so_oe = 1'b1;
                n.state = SFC_D_DOUT;
              end
            end
            SFC_D_DIN:
            begin
              // Cannot stall the link clock, so a full buffer drops the byte
              if (n.fcnt == 2'h2)
              begin
                n.overrun = 1'b1;
              end
              else
              begin
                n.fifo[r.wptr] = sh_new;
                n.wptr = ~r.wptr;
                n.fcnt = n.fcnt + 2'h1;
              end
            end
            SFC_D_DOUT:
            begin
              n.rd_req = 1'b1;
            end
            default:
            begin
              n.state = r.state;
            end
          endcase
        end
      end
      if (sck_fall && r.state == SFC_D_DOUT)
      begin
        n.ocnt = r.ocnt + 3'h1;
        if (r.ocnt == 3'h0)
        begin
          n.so = i_rd_data[7];
          n.osh = {i_rd_data[6:0], 1'b0};
        end
        else
        begin
          n.so = r.osh[7];
          n.osh = {r.osh[6:0], 1'b0};
        end
      end
    end
    n.wr_valid = n.fcnt != 2'h0;
    n.wr_data = n.fifo[n.rptr];
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      r <= '0;
      r.cpol <= `SFC_CPOL_RST;
    end
    else
    begin
      r <= n;
    end
  end

  assign bus.so = r.so;
  assign bus.so_oe = r.so_oe;
  assign bus.rdy_oe = r.rdy_oe;
  assign o_cmd_valid = r.cmd_valid;
  assign o_cmd_op = r.op;
  assign o_cmd_page = r.cmd_page;
  assign o_cmd_byte = r.cmd_byte;
  assign o_cmd_exec = r.cmd_exec;
  assign o_cmd_refused = r.cmd_refused;
  assign o_cpol = r.cpol;
  assign o_rd_req = r.rd_req;
  assign o_wr_valid = r.wr_valid;
  assign o_wr_data = r.wr_data;
  assign o_wr_overrun = r.overrun;
endmodule // sfc_device

// >>> testbench/sfc_link_chk.sv
// Wire checks on the link between host and device
`timescale 1ns/1ps
module sfc_link_chk (
  // Clock, reset and link wires
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire logic rst_n
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);
  // Clock parked while select settles, else the first bit is ambiguous
  sequence s_lead;
    (!cs_n && $stable(sck)) [*8];
  endsequence
  sequence s_pin_low;
    $fell(rst_n) ##1 !rst_n [*4];
  endsequence
  property p_lead; $fell(cs_n) |=> s_lead; endproperty
  property p_gap; $rose(cs_n) |=> cs_n [*8]; endproperty
  property p_idle_float; cs_n [*8] |-> !so_oe; endproperty
  property p_end_float; $rose(cs_n) |-> ##[1:6] !so_oe; endproperty
  property p_pin_float; s_pin_low |-> !so_oe; endproperty
  property p_so_fall; so_oe && $past(so_oe) && $changed(so) |-> !sck && !$past(sck, 2); endproperty
  // Enable follows the synchronised rising edge that ends the last non-data byte
  property p_oe_data; $rose(so_oe) |-> !cs_n && $past(sck, 3); endproperty
  property p_si_hold; $rose(sck) && !cs_n |-> si == $past(si, 3); endproperty
  a_lead: assert property (p_lead) else $error("short select lead");
  a_gap: assert property (p_gap) else $error("short select gap");
  a_idle_float: assert property (p_idle_float) else $error("output driven while idle");
  a_end_float: assert property (p_end_float) else $error("output kept after frame");
  a_pin_float: assert property (p_pin_float) else $error("output driven in reset");
  a_so_fall: assert property (p_so_fall) else $error("output moved off falling clock");
  a_oe_data: assert property (p_oe_data) else $error("output enabled out of frame");
  a_si_hold: assert property (p_si_hold) else $error("input moved near rising clock");
endmodule // sfc_link_chk

// >>> testbench/serial_flash_command_front_end_tb.sv
// Bench: host and device joined over one link
`timescale 1ns/1ps
`include "sfc_defines.svh"
module serial_flash_command_front_end_tb;
  logic        clk = 1'b0, rst = 1'b1, st = 1'b0, cp = 1'b0, wp = 1'b1, cr = 1'b1, bz = 1'b0, b2 = 1'b0;
  logic        wrr = 1'b0, rdy, href, hbz, ack, rxv, cv, cx, cref, dcp, rq, wv, ovr;
  logic [7:0]  op = 8'h00, td = 8'h10, rdd = 8'hA5, cop, rxd, wd, rxl, fw, t0;
  logic [10:0] pg = 11'h000, cpg;
  logic [8:0]  ba = 9'h000, ln = 9'h000, cby;
  int          fails = 0, checks_done = 0, cyc = 0, nv, nr, nx, nh, nw, nq;
  sfc_if sfc_if_i ();
  sfc_host #(.POWER_CYC(50)) sfc_host_i (.i_core_clk(clk), .i_reset(rst), .bus(sfc_if_i), .i_start(st),
    .i_op(op), .i_page(pg), .i_byte(ba), .i_len(ln), .i_cpol(cp), .i_wp_n(wp), .i_chip_rst_n(cr),
    .o_ready(rdy), .o_refused(href), .o_busy(hbz), .i_tx_valid(1'b1), .i_tx_data(td), .o_tx_ack(ack),
    .o_rx_valid(rxv), .o_rx_data(rxd));
  sfc_device sfc_device_i (.i_core_clk(clk), .i_reset(rst), .bus(sfc_if_i), .o_cmd_valid(cv),
    .o_cmd_op(cop), .o_cmd_page(cpg), .o_cmd_byte(cby), .o_cmd_exec(cx), .o_cmd_refused(cref),
    .o_cpol(dcp), .i_busy(bz), .i_busy_buf2(b2), .o_rd_req(rq), .i_rd_data(rdd), .o_wr_valid(wv),
    .o_wr_data(wd), .i_wr_ready(wrr), .o_wr_overrun(ovr));
  sfc_link_chk sfc_link_chk_i (.i_core_clk(clk), .i_reset(rst), .cs_n(sfc_if_i.cs_n), .sck(sfc_if_i.sck),
    .si(sfc_if_i.si), .so(sfc_if_i.so), .so_oe(sfc_if_i.so_oe), .rst_n(sfc_if_i.rst_n));
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Pulses are one cycle wide, so they are tallied here
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cv === 1'b1) nv <= nv + 1;
    if (cref === 1'b1) nr <= nr + 1;
    if (cx === 1'b1) nx <= nx + 1;
    if (rq === 1'b1) nq <= nq + 1;
    if (href === 1'b1) nh <= nh + 1;
    if (rxv === 1'b1) rxl <= rxd;
    if (ack === 1'b1) td <= #1 td + 8'h01;
    if (wv === 1'b1 && wrr === 1'b1 && nw == 0) fw <= wd;
    if (wv === 1'b1 && wrr === 1'b1) nw <= nw + 1;
    if (cyc == 30000)
    begin
      fails++;
      conclude();
    end
  end
  task automatic cmd(input logic [7:0] o, input logic [10:0] p, input logic [8:0] b, input logic [8:0] l,
                     input logic c);
    int k;
    for (k = 0; k < 9000 && rdy !== 1'b1; k++) @(posedge clk) #1;
    {nv, nr, nx, nh, nw, nq} = '0;
    {op, pg, ba, ln, cp, st} = {o, p, b, l, c, 1'b1};
    @(posedge clk) #1;
    st = 1'b0;
    @(posedge clk) #1;
    for (k = 0; k < 9000 && rdy !== 1'b1; k++) @(posedge clk) #1;
    // Exec pulse follows select rise through the synchroniser
    repeat (40) @(posedge clk) #1;
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    cmd(`SFC_OP_STAT, 11'h000, 9'h000, 9'h001, 1'b0);
    chk(nv, 1);
    chk(rxl, 8'hA5);
    // One fetch opens the data phase, one more at the end of each data byte
    chk(nq, 2);
    chk(dcp, 1'b0);
    cmd(`SFC_OP_PERASE, 11'h5A3, 9'h000, 9'h000, 1'b1);
    chk(cpg, 11'h5A3);
    chk(cop, `SFC_OP_PERASE);
    chk(nx, 1);
    chk(dcp, 1'b1);
    cmd(`SFC_OP_BERASE, 11'h7FF, 9'h1FF, 9'h000, 1'b0);
    chk(cpg, 11'h7F8);
    wp = 1'b0;
    cmd(`SFC_OP_PERASE, 11'h0FF, 9'h000, 9'h000, 1'b0);
    chk(nr, 1);
    chk(nx, 0);
    cmd(`SFC_OP_PERASE, 11'h100, 9'h000, 9'h000, 1'b0);
    chk(nx, 1);
    wp = 1'b1;
    t0 = td;
    cmd(`SFC_OP_B1WR, 11'h3C3, 9'h1AB, 9'h003, 1'b1);
    chk({cpg, cby}, {11'h000, 9'h1AB});
    chk(ovr, 1'b1);
    wrr = 1'b1;
    repeat (8) @(posedge clk) #1;
    chk(nw, 2);
    chk(fw, t0);
    bz = 1'b1;
    repeat (8) @(posedge clk) #1;
    chk(hbz, 1'b1);
    cmd(`SFC_OP_PERASE, 11'h200, 9'h000, 9'h000, 1'b0);
    chk(nh, 1);
    rdd = 8'h3C;
    cmd(`SFC_OP_B2RD, 11'h000, 9'h005, 9'h001, 1'b0);
    chk(rxl, 8'h3C);
    cmd(`SFC_OP_B1RD, 11'h000, 9'h005, 9'h001, 1'b0);
    chk(nr, 1);
    bz = 1'b0;
    // Let the ready line clear first, else the host refuses the start
    repeat (8) @(posedge clk) #1;
    // Mode 0 here so that the pin reset below must bring mode 3 back
    cmd(8'hFF, 11'h000, 9'h000, 9'h000, 1'b0);
    chk(nh, 0);
    chk(nv + nr, 0);
    // Pin drops in mid-opcode; select is high again before release
    fork
      cmd(`SFC_OP_STAT, 11'h000, 9'h000, 9'h001, 1'b0);
      #1000 cr = 1'b0;
    join
    chk(nv, 0);
    chk(dcp, 1'b1);
    cr = 1'b1;
    cmd(`SFC_OP_STAT, 11'h000, 9'h000, 9'h001, 1'b0);
    chk(nv, 1);
    conclude();
  end
endmodule // serial_flash_command_front_end_tb
